// *** adcc_pkg.sv ***
// Purpose: shared constants and types of the converter control block
// Assumes: 20 MHz mclk_i, Avalon-MM register slave with byte addresses
// Notes:   cycle counts derive from times in ns; least times round up
package adcc_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int CONV_MAX_NS   = 15000;
	localparam int CONV_MAX_CYC  = CONV_MAX_NS / CLK_PERIOD_NS;
	localparam int SAMPLE_NS     = 2000;
	localparam int SAMPLE_CYC    = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BIT_NS        = 400;
	localparam int BIT_CYC       = (BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Widths
	localparam int RES_W = 12;
	localparam int CNT_W = 8;
	localparam int DLY_W = 16;

	// Register byte offsets
	localparam logic [4:0] OFS_CTRL   = 5'h00;
	localparam logic [4:0] OFS_DELAY  = 5'h04;
	localparam logic [4:0] OFS_STAT   = 5'h08;
	localparam logic [4:0] OFS_MASK   = 5'h0C;
	localparam logic [4:0] OFS_RESULT = 5'h10;
	localparam logic [4:0] OFS_STATE  = 5'h14;

	// Control field positions
	localparam int CB_DIFF     = 0;
	localparam int CB_CH_LO    = 1;
	localparam int CB_PREF_LO  = 4;
	localparam int CB_NREF_LO  = 6;
	localparam int CB_TRIG     = 8;
	localparam int CB_FILT     = 9;
	localparam int CB_TOUCH_LO = 10;
	localparam int CB_START    = 16;

	// Status and mask bit positions
	localparam int SB_DONE = 0;
	localparam int SB_PEN  = 1;
	localparam int SB_N    = 2;

	// Reset values and the first trial code
	localparam logic [DLY_W-1:0] DELAY_RST = 16'h0000;
	localparam logic [SB_N-1:0]  MASK_RST  = 2'h0;
	localparam logic [2:0]       CH_RST    = 3'h0;
	localparam logic [3:0]       TOUCH_RST = 4'h0;
	localparam logic [RES_W-1:0] SAR_MID   = 12'h800;

	typedef enum logic [1:0] {
		PREF_SUPPLY = 2'b00,
		PREF_PIN    = 2'b01,
		PREF_IN0    = 2'b10,
		PREF_IN3    = 2'b11
	} adcc_pref_t;

	typedef enum logic [1:0] {
		NREF_SUPPLY = 2'b00,
		NREF_IN1    = 2'b01,
		NREF_IN2    = 2'b10
	} adcc_nref_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_DELAY = 2'b01,
		ST_CONV  = 2'b10
	} adcc_seq_t;

	typedef enum logic [1:0] {
		SAR_IDLE   = 2'b00,
		SAR_SAMPLE = 2'b01,
		SAR_BIT    = 2'b10
	} adcc_sar_t;

endpackage : adcc_pkg

// *** adcc_sar.sv ***
// Purpose: successive approximation engine, one 12-bit result per start
// Assumes: cmp_i already synchronised, high when input is above the trial
// Notes:   sample phase then one trial per bit, MSB first
`timescale 1ns/10ps
module adcc_sar (
	input  wire logic              mclk_i,
	input  wire logic              rst_n_i,
	input  wire logic              start_i,
	input  wire logic              cmp_i,
	output logic                   sample_o,
	output logic [11:0]            dac_code_o,
	output logic [11:0]            result_o,
	output logic                   done_o
);
	import adcc_pkg::*;

	localparam int CONV_LIM = CONV_MAX_CYC;

	adcc_sar_t         st;
	logic [CNT_W-1:0]  cnt;
	logic [3:0]        idx;
	logic [11:0]       kept;

	// Trial bit kept or dropped by the comparator
	always_comb
	begin
		kept = dac_code_o;
		kept[idx] = cmp_i;
	end

	// Sample, then twelve timed trials
	always_ff @(posedge mclk_i)
	begin
		done_o <= 1'b0;
		if (!rst_n_i)
		begin
			st         <= SAR_IDLE;
			cnt        <= '0;
			idx        <= 4'hB;
			sample_o   <= 1'b0;
			dac_code_o <= 12'h000;
			result_o   <= 12'h000;
		end
		else
		begin
			case (st)
				SAR_IDLE:
				begin
					if (start_i)
					begin
						st       <= SAR_SAMPLE;
						sample_o <= 1'b1;
						cnt      <= CNT_W'(SAMPLE_CYC - 1);
					end
				end
				SAR_SAMPLE:
				begin
					if (cnt == '0)
					begin
						st         <= SAR_BIT;
						sample_o   <= 1'b0;
						dac_code_o <= SAR_MID;
						idx        <= 4'hB;
						cnt        <= CNT_W'(BIT_CYC - 1);
					end
					else
						cnt <= cnt - 1'b1;
				end
				SAR_BIT:
				begin
					if (cnt != '0)
						cnt <= cnt - 1'b1;
					else if (idx == 4'h0)
					begin
						result_o   <= kept;
						dac_code_o <= kept;
						done_o     <= 1'b1;
						st         <= SAR_IDLE;
					end
					else
					begin
						dac_code_o          <= kept;
						dac_code_o[idx - 1] <= 1'b1;
						idx                 <= idx - 1'b1;
						cnt                 <= CNT_W'(BIT_CYC - 1);
					end
				end
				default: st <= SAR_IDLE;
			endcase
		end
	end

	conv_time_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(start_i && st == SAR_IDLE) |-> ##[1:CONV_LIM] done_o)
		else $error("conversion exceeded its time limit");

	sample_first_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(start_i && st == SAR_IDLE) |=> sample_o ##1 (sample_o || st == SAR_BIT))
		else $error("conversion did not open with a sample phase");

	done_pulse_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		done_o |-> result_o == $past(kept) ##1 !done_o)
		else $error("done not a single pulse with its result");

endmodule : adcc_sar

// *** adcc_top.sv ***
// Purpose: converter control with channel, reference, trigger and touch logic
// Assumes: Avalon-MM slave, one clock, comparator and pen inputs are async
// Notes:   waitrequest drops one cycle after a request; interrupt is a level
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps

// Functional notes
// - Eight inputs, or four differential pairs
// - Each conversion yields a twelve-bit result
// - Conversion completes within fifteen microseconds
// - External trigger starts after programmed delay
// - Done flag polled, optional interrupt raised
// - Single-ended: convert chosen channel, then stop
// - Differential: convert chosen pair, then stop
// - Positive reference from four sources
// - Negative reference from three sources
// - Drive touchscreen switches on four inputs
// - Detect pen-down and report it
// - Route mux output to external filter pins
module adcc_top (
	input  wire logic                 mclk_i,
	input  wire logic                 rst_n_i,
	input  wire logic [4:0]           avs_address_i,
	input  wire logic                 avs_read_i,
	input  wire logic                 avs_write_i,
	input  wire logic [31:0]          avs_writedata_i,
	input  wire logic [3:0]           avs_byteenable_i,
	output logic [31:0]               avs_readdata_o,
	output logic                      avs_waitrequest_o,
	output logic                      irq_o,
	input  wire logic                 cmp_i,
	input  wire logic                 pen_i,
	input  wire logic                 ext_trig_i,
	output logic [2:0]                ch_sel_o,
	output logic                      diff_mode_o,
	output adcc_pkg::adcc_pref_t      pos_ref_o,
	output adcc_pkg::adcc_nref_t      neg_ref_o,
	output logic                      ext_filter_o,
	output logic [3:0]                touch_sw_o,
	output logic                      sample_o,
	output logic [11:0]               dac_code_o
);
	import adcc_pkg::*;

	// Merge write data into a register under byte enables
	function automatic logic [31:0] be_merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = wd[8*i +: 8];
		return r;
	endfunction : be_merge

	// Synchronisers and edge history
	logic [2:0]             sync1;
	logic [2:0]             sync2;
	logic                   pen_q;
	logic                   trig_q;

	// Registers and sequencer state
	logic                   trig_en;
	logic [DLY_W-1:0]       dly;
	logic [DLY_W-1:0]       dly_cnt;
	logic [SB_N-1:0]        sts;
	logic [SB_N-1:0]        msk;
	adcc_seq_t              st;
	logic                   conv_go;
	logic [11:0]            result;
	logic                   sar_done;

	// Decode and combinational terms
	logic                   wr_go;
	logic [31:0]            ctrl_word;
	logic [31:0]            ctrl_new;
	logic                   sw_start;
	logic                   trig_hit;
	logic                   pen_rise;
	logic                   launch;
	logic [SB_N-1:0]        w1c;
	logic [SB_N-1:0]        next_sts;
	logic [31:0]            rd_mux;
	logic [31:0]            dly_new;
	logic [31:0]            msk_new;

	// Two flops before any logic sees the pins
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
		end
		else
		begin
			sync1 <= {ext_trig_i, pen_i, cmp_i};
			sync2 <= sync1;
		end
	end

	// Edge history for trigger and pen
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			pen_q  <= 1'b0;
			trig_q <= 1'b0;
		end
		else
		begin
			pen_q  <= sync2[1];
			trig_q <= sync2[2];
		end
	end

	assign pen_rise = sync2[1] & ~pen_q;
	assign trig_hit = trig_en & sync2[2] & ~trig_q;

	// Waitrequest: low for exactly one cycle per access
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			avs_waitrequest_o <= 1'b1;
		else if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
			avs_waitrequest_o <= 1'b0;
		else
			avs_waitrequest_o <= 1'b1;
	end

	assign wr_go = avs_write_i & ~avs_waitrequest_o;

	// Control word as software sees it; start always reads zero
	always_comb
	begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[CB_DIFF] = diff_mode_o;
		ctrl_word[CB_CH_LO +: 3] = ch_sel_o;
		ctrl_word[CB_PREF_LO +: 2] = pos_ref_o;
		ctrl_word[CB_NREF_LO +: 2] = neg_ref_o;
		ctrl_word[CB_TRIG] = trig_en;
		ctrl_word[CB_FILT] = ext_filter_o;
		ctrl_word[CB_TOUCH_LO +: 4] = touch_sw_o;
	end

	assign ctrl_new = be_merge(ctrl_word, avs_writedata_i, avs_byteenable_i);
	assign sw_start = wr_go && avs_address_i == OFS_CTRL && ctrl_new[CB_START];

	// Control register: mode, channel, references, routing, touch
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			diff_mode_o  <= 1'b0;
			ch_sel_o     <= CH_RST;
			pos_ref_o    <= PREF_SUPPLY;
			neg_ref_o    <= NREF_SUPPLY;
			trig_en      <= 1'b0;
			ext_filter_o <= 1'b0;
			touch_sw_o   <= TOUCH_RST;
		end
		else if (wr_go && avs_address_i == OFS_CTRL)
		begin
			diff_mode_o  <= ctrl_new[CB_DIFF];
			// In pair mode only the low two bits pick the pair
			ch_sel_o     <= ctrl_new[CB_CH_LO +: 3];
			pos_ref_o    <= adcc_pref_t'(ctrl_new[CB_PREF_LO +: 2]);
			// Code three names no source, so it falls back to supply
			if (ctrl_new[CB_NREF_LO +: 2] == 2'b11)
				neg_ref_o <= NREF_SUPPLY;
			else
				neg_ref_o <= adcc_nref_t'(ctrl_new[CB_NREF_LO +: 2]);
			trig_en      <= ctrl_new[CB_TRIG];
			ext_filter_o <= ctrl_new[CB_FILT];
			touch_sw_o   <= ctrl_new[CB_TOUCH_LO +: 4];
		end
	end

	// Delay and mask registers; merged words are sliced here, not at the call
	assign dly_new = be_merge({16'h0000, dly}, avs_writedata_i, avs_byteenable_i);
	assign msk_new = be_merge({30'h0, msk}, avs_writedata_i, avs_byteenable_i);

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			dly <= DELAY_RST;
			msk <= MASK_RST;
		end
		else if (wr_go)
		begin
			if (avs_address_i == OFS_DELAY)
				dly <= dly_new[DLY_W-1:0];
			if (avs_address_i == OFS_MASK)
				msk <= msk_new[SB_N-1:0];
		end
	end

	// A start is taken only from idle; anything else is dropped
	assign launch = (st == ST_IDLE) && (sw_start || trig_hit);

	// Sequencer: idle, trigger delay, one conversion, back to idle
	always_ff @(posedge mclk_i)
	begin
		conv_go <= 1'b0;
		if (!rst_n_i)
		begin
			st      <= ST_IDLE;
			dly_cnt <= '0;
		end
		else
		begin
			case (st)
				ST_IDLE:
				begin
					if (sw_start || (trig_hit && dly == '0))
					begin
						conv_go <= 1'b1;
						st      <= ST_CONV;
					end
					else if (trig_hit)
					begin
						dly_cnt <= dly;
						st      <= ST_DELAY;
					end
				end
				ST_DELAY:
				begin
					if (dly_cnt == 16'h0001)
					begin
						conv_go <= 1'b1;
						st      <= ST_CONV;
					end
					dly_cnt <= dly_cnt - 1'b1;
				end
				ST_CONV:
				begin
					// One conversion only, then wait for the next start
					if (sar_done)
						st <= ST_IDLE;
				end
				default: st <= ST_IDLE;
			endcase
		end
	end

	adcc_sar adcc_sar_inst (
		.mclk_i     (mclk_i),
		.rst_n_i    (rst_n_i),
		.start_i    (conv_go),
		.cmp_i      (sync2[0]),
		.sample_o   (sample_o),
		.dac_code_o (dac_code_o),
		.result_o   (result),
		.done_o     (sar_done)
	);

	// Sticky status: set beats write-one clear
	always_comb
	begin
		w1c = '0;
		if (wr_go && avs_address_i == OFS_STAT)
			w1c = avs_writedata_i[SB_N-1:0] & {SB_N{avs_byteenable_i[0]}};
		next_sts = sts & ~w1c;
		if (launch)
			next_sts[SB_DONE] = 1'b0;
		if (sar_done)
			next_sts[SB_DONE] = 1'b1;
		if (pen_rise)
			next_sts[SB_PEN] = 1'b1;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			sts <= '0;
		else
			sts <= next_sts;
	end

	// Level interrupt, one cycle behind the status bits
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(sts & msk);
	end

	// Read multiplexer; unmapped offsets read zero
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (avs_address_i)
			OFS_CTRL:   rd_mux = ctrl_word;
			OFS_DELAY:  rd_mux[DLY_W-1:0] = dly;
			OFS_STAT:   rd_mux[SB_N-1:0] = sts;
			OFS_MASK:   rd_mux[SB_N-1:0] = msk;
			OFS_RESULT: rd_mux[RES_W-1:0] = result;
			OFS_STATE:  rd_mux[2:0] = {st == ST_DELAY, sync2[1], st != ST_IDLE};
			default:    rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data stands from the cycle waitrequest drops
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			avs_readdata_o <= 32'h0000_0000;
		else if (avs_read_i && avs_waitrequest_o)
			avs_readdata_o <= rd_mux;
	end

	ans_wait_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		((avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o)
		else $error("bus access not answered in one cycle");

	done_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		sar_done |=> sts[SB_DONE] && st == ST_IDLE)
		else $error("done flag not set after conversion");

	irq_level_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		##1 irq_o == $past(|(sts & msk)))
		else $error("interrupt does not follow masked status");

	busy_ignore_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(st == ST_CONV && !sar_done && sw_start) |=> st == ST_CONV && !conv_go)
		else $error("start taken during a conversion");

	start_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		launch |=> !sts[SB_DONE])
		else $error("start did not clear done");

	pen_event_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		pen_rise |=> sts[SB_PEN])
		else $error("pen-down not reported");

	trig_delay_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(st == ST_IDLE && trig_hit && !sw_start && dly != '0)
			|=> st == ST_DELAY && dly_cnt == $past(dly) && !conv_go)
		else $error("trigger delay not honoured");

	delay_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(st == ST_DELAY && dly_cnt != 16'h0001) |=> st == ST_DELAY && !conv_go)
		else $error("conversion began before the delay ran out");

	delay_go_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(st == ST_DELAY && dly_cnt == 16'h0001) |=> st == ST_CONV && conv_go)
		else $error("conversion did not follow the delay");

	route_sel_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(wr_go && avs_address_i == OFS_CTRL && avs_byteenable_i[1])
			|=> ext_filter_o == $past(avs_writedata_i[CB_FILT]))
		else $error("filter routing bit not stored");

endmodule : adcc_top

// *** adcc_far_model.sv ***
// Purpose: far-side model of mux, comparator and touch panel
// Assumes: each input sits half a code above a whole code
// Notes:   fixed level per channel or pair, pen passed through
`timescale 1ns/10ps
module adcc_far_model (
	input  wire logic        diff_mode_i,
	input  wire logic [2:0]  ch_sel_i,
	input  wire logic [11:0] dac_code_i,
	input  wire logic        pen_down_i,
	output logic             cmp_o,
	output logic             pen_o
);
	logic [3:0]  idx;
	logic [11:0] level;
	// Pairs sit above the eight single inputs
	assign idx   = diff_mode_i ? {2'b10, ch_sel_i[1:0]} : {1'b0, ch_sel_i};
	assign level = 12'h0A5 + 12'h123 * {8'h00, idx};
	// Half code margin makes an exact code settle the same way every time
	assign cmp_o = (dac_code_i <= level);
	assign pen_o = pen_down_i;
endmodule : adcc_far_model

// *** adc_conversion_control_test.sv ***
// Purpose: self-checking bench for the converter control block
// Assumes: bus answers within 20 cycles, far model gives fixed levels
// Notes:   each scenario is its own task and judges its own results
`timescale 1ns/10ps
module adc_conversion_control_test;
	import adcc_pkg::*;
	logic        mclk_i, rst_n_i, avs_read_i, avs_write_i, irq_o, cmp_i, pen_i, ext_trig_i;
	logic        diff_mode_o, ext_filter_o, sample_o, avs_waitrequest_o, pen_down;
	logic [4:0]  avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, q;
	logic [3:0]  avs_byteenable_i, touch_sw_o;
	logic [2:0]  ch_sel_o;
	logic [11:0] dac_code_o;
	adcc_pref_t  pos_ref_o;
	adcc_nref_t  neg_ref_o;
	int          n_fail, n_checks;
	adcc_top adcc_top_inst (.mclk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o,
		.cmp_i, .pen_i, .ext_trig_i, .ch_sel_o, .diff_mode_o, .pos_ref_o, .neg_ref_o,
		.ext_filter_o, .touch_sw_o, .sample_o, .dac_code_o);
	adcc_far_model adcc_far_model_inst (.diff_mode_i(diff_mode_o), .ch_sel_i(ch_sel_o),
		.dac_code_i(dac_code_o), .pen_down_i(pen_down), .cmp_o(cmp_i), .pen_o(pen_i));
	// Clock, then reset held for sixteen cycles
	initial
	begin
		mclk_i = 0;
		forever #25 mclk_i = ~mclk_i;
	end
	task automatic results();
		if (n_fail == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Any exhausted wait ends the run as a failure
	task automatic give_up();
		n_fail++;
		results();
	endtask : give_up
	// One bus cycle; request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		for (i = 0; i < 20 && avs_waitrequest_o !== 1'b0; i++)
			@(posedge mclk_i);
		if (i == 20)
			give_up();
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask : bus
	function automatic logic [31:0] cw(input int dm, ch, p, n, ts, st);
		return {15'h0, st[0], 2'h0, ts[3:0], 2'h0, n[1:0], p[1:0], ch[2:0], dm[0]};
	endfunction : cw
	function automatic logic [31:0] lvl(input int i);
		return {20'h0, 12'h0A5 + 12'h123 * i[11:0]};
	endfunction : lvl
	// Poll status until done, bounded
	task automatic poll_done();
		int i;
		for (i = 0; i < 200; i++)
		begin
			bus(0, OFS_STAT, 0);
			if (q[SB_DONE] === 1'b1)
				break;
		end
		if (i == 200)
			give_up();
	endtask : poll_done
	task automatic t_reset();
		chk({irq_o, diff_mode_o, ch_sel_o, pos_ref_o, neg_ref_o, touch_sw_o, dac_code_o}, 0);
		for (int a = 0; a < 32; a += 4)
		begin
			bus(0, a[4:0], 0);
			chk(q, 0);
		end
	endtask : t_reset
	// Every reference code, channel and filter route, and eight of the sixteen touch patterns
	task automatic t_mux();
		for (int k = 0; k < 8; k++)
		begin
			bus(1, OFS_CTRL, cw(k, k, k, k % 3, k ^ 9, 0) | {22'h0, k[0], 9'h0});
			repeat (2) @(posedge mclk_i);
			chk({diff_mode_o, ch_sel_o, pos_ref_o, neg_ref_o, ext_filter_o, touch_sw_o},
				{k[0], k[2:0], k[1:0], 2'(k % 3), k[0], 4'(k ^ 9)});
		end
		// Code three names no source and must fall back to supply
		bus(1, OFS_CTRL, cw(0, 0, 0, 3, 0, 0));
		repeat (2) @(posedge mclk_i);
		chk(neg_ref_o, NREF_SUPPLY);
	endtask : t_mux
	// One conversion to an unmasked done; irq timing, result, stop
	task automatic t_conv(input int dm, input int ch, input int idx);
		int n;
		bus(1, OFS_MASK, 1);
		bus(1, OFS_CTRL, cw(dm, ch, 0, 0, 0, 1));
		for (n = 0; n < 310 && irq_o !== 1'b1; n++)
			@(posedge mclk_i);
		if (n == 310)
			give_up();
		chk(n <= 302, 1);
		bus(0, OFS_RESULT, 0);
		chk(q, lvl(idx));
		n = 0;
		repeat (40) @(posedge mclk_i) n += sample_o;
		chk(n, 0);
		bus(1, OFS_STAT, 1);
		repeat (3) @(posedge mclk_i);
		chk(irq_o, 0);
	endtask : t_conv
	// Start while busy ignored, start clears done, masked irq quiet
	task automatic t_busy();
		bus(1, OFS_MASK, 0);
		bus(1, OFS_CTRL, cw(0, 1, 0, 0, 0, 1));
		repeat (60) @(posedge mclk_i);
		bus(1, OFS_CTRL, cw(0, 1, 0, 0, 0, 1));
		poll_done();
		bus(0, OFS_STATE, 0);
		chk(q[0], 0);
		chk(irq_o, 0);
		bus(0, OFS_RESULT, 0);
		chk(q, lvl(1));
		bus(1, OFS_CTRL, cw(0, 1, 0, 0, 0, 1));
		bus(0, OFS_STAT, 0);
		chk(q[SB_DONE], 0);
		poll_done();
		bus(1, OFS_MASK, 1);
		repeat (3) @(posedge mclk_i);
		chk(irq_o, 1);
		bus(1, OFS_STAT, 1);
	endtask : t_busy
	// External trigger waits the programmed delay
	task automatic t_trig();
		realtime t0;
		int i;
		bus(1, OFS_DELAY, 40);
		bus(1, OFS_CTRL, 32'h100 | cw(0, 2, 0, 0, 0, 0));
		@(posedge mclk_i);
		ext_trig_i <= 1'b1;
		t0 = $realtime;
		repeat (10) @(posedge mclk_i);
		ext_trig_i <= 1'b0;
		bus(0, OFS_STATE, 0);
		chk(q[2], 1);
		for (i = 0; i < 200 && sample_o !== 1'b1; i++)
			@(posedge mclk_i);
		if (i == 200)
			give_up();
		i = int'(($realtime - t0) / 50.0);
		chk(i >= 43 && i <= 47, 1);
		poll_done();
		bus(0, OFS_RESULT, 0);
		chk(q, lvl(2));
	endtask : t_trig
	// Pen-down reported as level and sticky event
	task automatic t_pen();
		pen_down <= 1'b1;
		repeat (5) @(posedge mclk_i);
		bus(0, OFS_STATE, 0);
		chk(q[1], 1);
		bus(1, OFS_MASK, 2);
		bus(0, OFS_STAT, 0);
		chk({q[SB_PEN], irq_o}, 2'b11);
		bus(1, OFS_STAT, 2);
		bus(0, OFS_STAT, 0);
		chk(q[SB_PEN], 0);
	endtask : t_pen
	// Main sequence
	initial
	begin
		{rst_n_i, avs_read_i, avs_write_i, ext_trig_i, pen_down} = 0;
		{avs_address_i, avs_writedata_i, avs_byteenable_i} = {5'h0, 32'h0, 4'hF};
		repeat (16) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		@(posedge mclk_i);
		t_reset();
		t_mux();
		t_conv(0, 5, 5);
		t_conv(1, 6, 10);
		t_busy();
		t_trig();
		t_pen();
		results();
	end
endmodule : adc_conversion_control_test
